// *** src/apc_pkg.sv ***
// Shared constants and types for the audio port and PLL configuration block.
package apc_pkg;

  // Register offsets.
  localparam logic [7:0] OFF_RX_PORT = 8'h0a;
  localparam logic [7:0] OFF_RX_FMT = 8'h0b;
  localparam logic [7:0] OFF_TX_PORT = 8'h0c;
  localparam logic [7:0] OFF_TX_FMT = 8'h0d;
  localparam logic [7:0] OFF_PLL_CTRL = 8'h14;
  localparam logic [7:0] OFF_FRAC_HI = 8'h15;
  localparam logic [7:0] OFF_FRAC_LO = 8'h16;
  localparam logic [7:0] OFF_LOOP_DIV = 8'h17;
  localparam logic [7:0] OFF_POPFREE = 8'h18;
  localparam logic [7:0] OFF_PLL_STAT = 8'h19;

  // Values after reset.
  localparam logic [7:0] RST_RX_PORT = 8'hd2;
  localparam logic [7:0] RST_RX_FMT = 8'h91;
  localparam logic [7:0] RST_TX_PORT = 8'hd3;
  localparam logic [7:0] RST_TX_FMT = 8'h91;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_POS = 8'hff;

  // Status field positions, which no struct carries, and the fault clear bit of the pop-free struct.
  localparam int STAT_UNLOCK_BIT = 7;
  localparam int STAT_PWD_BIT = 6;
  localparam int STAT_BYP_BIT = 5;
  localparam int FAULT_CLEAR_BIT = 0;

  // Protocol format codes.
  localparam logic [2:0] FMT_LEFT = 3'h0;
  localparam logic [2:0] FMT_I2S = 3'h1;
  localparam logic [2:0] FMT_RIGHT = 3'h2;
  localparam logic [2:0] FMT_PCM = 3'h4;
  localparam logic [2:0] FMT_PCM_DLY = 3'h5;
  localparam logic [2:0] FMT_RSVD = 3'h6;
  localparam logic [2:0] FMT_DSP = 3'h7;

  // Divider and multiplier limits.
  localparam logic [3:0] IN_DIV_MIN = 4'h1;
  localparam logic [5:0] LOOP_MIN = 6'h05;

  // Serial frame geometry.
  localparam int SAMPLE_W = 24;
  localparam int FIFO_DEPTH = 16;
  localparam logic [7:0] SLOT_BITS = 8'h20;
  localparam logic [7:0] BYTE_BITS = 8'h08;

  // Timing: master bit clock half period.
  localparam int MCLK_MHZ = 100;
  localparam int BCLK_HALF_NS = 80;
  localparam int BCLK_HALF_CYC_I = (BCLK_HALF_NS * MCLK_MHZ / 1000 < 1) ? 1 :
                                   BCLK_HALF_NS * MCLK_MHZ / 1000;
  localparam logic [7:0] BCLK_HALF_CYC = 8'(BCLK_HALF_CYC_I);

  typedef enum logic [5:0] {
    I2C_IDLE = 6'h01,
    I2C_DEV = 6'h02,
    I2C_ACK = 6'h04,
    I2C_RX = 6'h08,
    I2C_TX = 6'h10,
    I2C_RACK = 6'h20
  } apc_i2c_e;

  typedef struct packed {
    logic bit_clock_edge_select;
    logic frame_left_high;
    logic tx_idle_drive;
    logic msb_first;
    logic [2:0] format;
    logic master;
  } apc_port_s;

  typedef struct packed {
    logic [1:0] word_length_field;
    logic [1:0] bit_clock_ratio;
    logic [1:0] slot_left;
    logic [1:0] slot_right;
  } apc_fmt_s;

  typedef struct packed {
    logic pll_manual_program;
    logic fractional_enable;
    logic rect_dither_off;
    logic tri_dither_off;
    logic [3:0] input_divider;
  } apc_pll_ctrl_s;

  typedef struct packed {
    logic fraction_strobe;
    logic strobe_bypass;
    logic [5:0] loop_divider;
  } apc_loopdiv_s;

  typedef struct packed {
    logic bypass_when_unlocked;
    logic bitclk_as_reference;
    logic pll_power_off;
    logic popfree_out_1a;
    logic popfree_out_1b;
    logic popfree_out_2a;
    logic popfree_out_2b;
    logic fault_clear;
  } apc_popfree_s;

  typedef struct packed {
    logic run_manual;
    logic fractional_enable;
    logic rect_dither_off;
    logic tri_dither_off;
    logic [3:0] input_divider;
    logic [5:0] loop_factor;
    logic [15:0] fraction_value;
    logic fraction_strobe;
    logic strobe_bypass;
    logic bypass_when_unlocked;
    logic bitclk_as_reference;
    logic pll_power_off;
  } apc_pll_s;

endpackage

// *** src/apc_regs.sv ***
// Audio serial port and PLL configuration registers with I2C access and transmit serializer.
`timescale 1ns/1ns

module apc_sync3 #(
  parameter logic INIT = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Level in and filtered level out
  input wire logic d,
  output logic q
);
  logic s1_r, s2_r, s3_r;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // A change is accepted only once the last two stages agree.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      q <= INIT;
    else if (s2_r == s3_r)
      q <= s3_r;
  end
endmodule

module apc_fifo #(
  parameter int W = 24,
  parameter int D = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  localparam logic [AW:0] FULL = (AW+1)'(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rd_ptr_r];

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 1'b1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= (wr_ptr_r == AW'(D - 1)) ? '0 : wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= (rd_ptr_r == AW'(D - 1)) ? '0 : rd_ptr_r + 1'b1;
      cnt_r <= cnt_nxt;
      in_ready <= (cnt_nxt != FULL);
    end
  end
endmodule

module apc_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // Arbitrary bus address.
) (
  // System
  input wire logic mclk,
  input wire logic rst_n,
  // I2C control port
  input wire logic i2c_scl,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe,
  // Sample stream into the transmit port
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic [apc_pkg::SAMPLE_W-1:0] smp_data,
  // Transmit serial port pins
  input wire logic bit_clock_input,
  input wire logic frame_clock_input,
  output logic bit_clock_out,
  output logic bit_clock_oe,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  // PLL
  input wire logic pll_lock,
  output apc_pkg::apc_pll_s pll_cfg,
  // Receive port and output stage controls
  output apc_pkg::apc_port_s rx_port_cfg,
  output apc_pkg::apc_fmt_s rx_fmt_cfg,
  output logic [3:0] popfree_out,
  output logic bridge_fault_clear
);
  import apc_pkg::*;

  apc_port_s rx_port_r, tx_port_r;
  apc_fmt_s rx_fmt_r, tx_fmt_r;
  apc_pll_ctrl_s pll_ctrl_r;
  apc_loopdiv_s loop_r;
  apc_popfree_s pop_r;
  logic [7:0] frac_hi_r, frac_lo_r;
  logic scl_q, sda_q, bclk_q, frm_q, lock_q;
  logic scl_p_r, sda_p_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  apc_i2c_e state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, ptr_r, rdata;
  logic rw_r, have_ptr_r, wr_en;
  logic unlocked;

  apc_sync3 #(.INIT(1'b1)) u_scl (.mclk(mclk), .rst_n(rst_n), .d(i2c_scl), .q(scl_q));
  apc_sync3 #(.INIT(1'b1)) u_sda (.mclk(mclk), .rst_n(rst_n), .d(i2c_sda_in), .q(sda_q));
  apc_sync3 #(.INIT(1'b0)) u_bck (.mclk(mclk), .rst_n(rst_n), .d(bit_clock_input),
                                  .q(bclk_q));
  apc_sync3 #(.INIT(1'b0)) u_frm (.mclk(mclk), .rst_n(rst_n), .d(frame_clock_input),
                                  .q(frm_q));
  apc_sync3 #(.INIT(1'b0)) u_lck (.mclk(mclk), .rst_n(rst_n), .d(pll_lock), .q(lock_q));

  assign scl_rise = scl_q && !scl_p_r;
  assign scl_fall = !scl_q && scl_p_r;
  assign start_c = scl_q && scl_p_r && sda_p_r && !sda_q;
  assign stop_c = scl_q && scl_p_r && !sda_p_r && sda_q;
  assign wr_en = (state_r == I2C_RX) && scl_fall && (bit_cnt_r == 4'h8) && have_ptr_r;
  assign unlocked = !lock_q;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
      i2c_sda_out <= 1'b0;
    end
    else
    begin
      scl_p_r <= scl_q;
      sda_p_r <= sda_q;
      i2c_sda_out <= 1'b0;
    end
  end

  // Read mux; the status word is built live from the PLL condition each read.
  always_comb
  begin
    rdata = 8'h00;
    unique case (ptr_r)
      OFF_RX_PORT: rdata = rx_port_r;
      OFF_RX_FMT: rdata = rx_fmt_r;
      OFF_TX_PORT: rdata = tx_port_r;
      OFF_TX_FMT: rdata = tx_fmt_r;
      OFF_PLL_CTRL: rdata = pll_ctrl_r;
      OFF_FRAC_HI: rdata = frac_hi_r;
      OFF_FRAC_LO: rdata = frac_lo_r;
      OFF_LOOP_DIV: rdata = loop_r;
      OFF_POPFREE: rdata = pop_r;
      OFF_PLL_STAT:
      begin
        rdata[STAT_UNLOCK_BIT] = unlocked;
        rdata[STAT_PWD_BIT] = pop_r.pll_power_off;
        rdata[STAT_BYP_BIT] = pop_r.bypass_when_unlocked && unlocked;
      end
      default: rdata = 8'h00;
    endcase
  end

  // I2C slave: address byte, register pointer, then data with auto-increment.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state_r <= I2C_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      have_ptr_r <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end
    else if (start_c)
    begin
      state_r <= I2C_DEV;
      bit_cnt_r <= 4'h0;
      have_ptr_r <= 1'b0;
      i2c_sda_oe <= 1'b0;
    end
    else if (stop_c)
    begin
      state_r <= I2C_IDLE;
      i2c_sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        I2C_IDLE: ;
        I2C_DEV, I2C_RX:
        begin
          if (scl_rise && bit_cnt_r != 4'h8)
          begin
            shift_r <= {shift_r[6:0], sda_q};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          else if (scl_fall && bit_cnt_r == 4'h8)
          begin
            if (state_r == I2C_DEV)
            begin
              if (shift_r[7:1] == DEV_ADDR)
              begin
                state_r <= I2C_ACK;
                rw_r <= shift_r[0];
                i2c_sda_oe <= 1'b1;
              end
              else
                state_r <= I2C_IDLE;
            end
            else
            begin
              if (have_ptr_r)
                ptr_r <= ptr_r + 8'h01;
              else
                ptr_r <= shift_r;
              have_ptr_r <= 1'b1;
              state_r <= I2C_ACK;
              i2c_sda_oe <= 1'b1;
            end
          end
        end
        I2C_ACK, I2C_RACK:
        begin
          if (state_r == I2C_RACK && scl_rise && sda_q)
            state_r <= I2C_IDLE;
          else if (scl_fall)
          begin
            if (rw_r)
            begin
              state_r <= I2C_TX;
              shift_r <= rdata;
              i2c_sda_oe <= !rdata[7];
              ptr_r <= ptr_r + 8'h01;
              bit_cnt_r <= 4'h1;
            end
            else
            begin
              state_r <= I2C_RX;
              i2c_sda_oe <= 1'b0;
              bit_cnt_r <= 4'h0;
            end
          end
        end
        I2C_TX:
        begin
          if (scl_fall)
          begin
            if (bit_cnt_r == 4'h8)
            begin
              state_r <= I2C_RACK;
              i2c_sda_oe <= 1'b0;
            end
            else
            begin
              i2c_sda_oe <= !shift_r[6];
              shift_r <= {shift_r[6:0], 1'b0};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end
          end
        end
        default: state_r <= I2C_IDLE;
      endcase
    end
  end

  // Register file; the status offset has no storage so writes there fall away.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_port_r <= RST_RX_PORT;
      rx_fmt_r <= RST_RX_FMT;
      tx_port_r <= RST_TX_PORT;
      tx_fmt_r <= RST_TX_FMT;
      pll_ctrl_r <= RST_ZERO;
      frac_hi_r <= RST_ZERO;
      frac_lo_r <= RST_ZERO;
      loop_r <= RST_ZERO;
      pop_r <= RST_ZERO;
      bridge_fault_clear <= 1'b0;
    end
    else
    begin
      bridge_fault_clear <= wr_en && ptr_r == OFF_POPFREE && shift_r[FAULT_CLEAR_BIT];
      if (wr_en)
      begin
        unique case (ptr_r)
          OFF_RX_PORT: rx_port_r <= shift_r;
          OFF_RX_FMT: rx_fmt_r <= shift_r;
          OFF_TX_PORT: tx_port_r <= shift_r;
          OFF_TX_FMT: tx_fmt_r <= shift_r;
          OFF_PLL_CTRL: pll_ctrl_r <= shift_r;
          OFF_FRAC_HI: frac_hi_r <= shift_r;
          OFF_FRAC_LO: frac_lo_r <= shift_r;
          OFF_LOOP_DIV: loop_r <= shift_r;
          OFF_POPFREE: pop_r <= {shift_r[7:1], 1'b0};
          default: ;
        endcase
      end
    end
  end

  // Outputs toward the receive port, pop-free switches and the analog PLL.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      rx_port_cfg <= RST_RX_PORT;
      rx_fmt_cfg <= RST_RX_FMT;
      popfree_out <= 4'h0;
      pll_cfg <= '0;
    end
    else
    begin
      rx_port_cfg <= rx_port_r;
      rx_fmt_cfg <= rx_fmt_r;
      popfree_out <= {pop_r.popfree_out_1a, pop_r.popfree_out_1b,
                      pop_r.popfree_out_2a, pop_r.popfree_out_2b};
      pll_cfg <= '0;
      pll_cfg.run_manual <= pll_ctrl_r.pll_manual_program;
      pll_cfg.bypass_when_unlocked <= pop_r.bypass_when_unlocked;
      pll_cfg.bitclk_as_reference <= pop_r.bitclk_as_reference;
      pll_cfg.pll_power_off <= pop_r.pll_power_off;
      if (pll_ctrl_r.pll_manual_program)
      begin
        pll_cfg.fractional_enable <= pll_ctrl_r.fractional_enable;
        pll_cfg.fraction_value <= pll_ctrl_r.fractional_enable ?
                                  {frac_hi_r, frac_lo_r} : 16'h0000;
        pll_cfg.rect_dither_off <= pll_ctrl_r.rect_dither_off;
        pll_cfg.tri_dither_off <= pll_ctrl_r.tri_dither_off;
        pll_cfg.input_divider <= (pll_ctrl_r.input_divider < IN_DIV_MIN) ?
                                 IN_DIV_MIN : pll_ctrl_r.input_divider;
        pll_cfg.loop_factor <= (loop_r.loop_divider < LOOP_MIN) ?
                               LOOP_MIN : loop_r.loop_divider;
        pll_cfg.fraction_strobe <= loop_r.fraction_strobe;
        pll_cfg.strobe_bypass <= loop_r.strobe_bypass;
      end
    end
  end

  // Transmit serializer.
  logic [SAMPLE_W-1:0] fifo_data, cur_l_r, cur_r_r, nxt_l_r, nxt_r_r, word_l, word_r;
  logic fifo_valid, fifo_pop;
  logic nxt_vl_r, nxt_vr_r, cur_v_r, load0, word_v;
  logic [7:0] div_r, bcnt_r, pos_c, fbits, half, wlen, sl, sr, kl, kr, idx;
  logic bclk_gen_r, bck_q_r, bck_p_r, frm_prev_r, launch, sof, tdm, dly;
  logic in_l, in_r, bit_c;
  logic [31:0] ext_w;

  apc_fifo #(.W(SAMPLE_W), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .in_data(smp_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  assign fbits = (8'(tx_fmt_r.bit_clock_ratio) + 8'h01) * SLOT_BITS;
  assign half = fbits >> 1;
  assign wlen = (8'(tx_fmt_r.word_length_field) + 8'h01) * BYTE_BITS;
  assign tdm = tx_port_r.format[2];
  assign dly = (tx_port_r.format == FMT_I2S) || (tx_port_r.format == FMT_PCM_DLY);
  assign launch = (bck_q_r != bck_p_r) && (bck_q_r != tx_port_r.bit_clock_edge_select);
  assign sof = launch && !tx_port_r.master && (frm_q == tx_port_r.frame_left_high) &&
               (frm_prev_r != tx_port_r.frame_left_high);

  always_comb
  begin
    if (tx_port_r.master)
      pos_c = (bcnt_r >= fbits - 8'h01) ? 8'h00 : bcnt_r + 8'h01;
    else if (sof)
      pos_c = 8'h00;
    else
      pos_c = (bcnt_r == RST_POS) ? RST_POS : bcnt_r + 8'h01;
    if (tdm)
    begin
      sl = 8'(tx_fmt_r.slot_left) * wlen + 8'(dly);
      sr = 8'(tx_fmt_r.slot_right) * wlen + 8'(dly);
    end
    else if (tx_port_r.format == FMT_RIGHT)
    begin
      sl = half - wlen;
      sr = fbits - wlen;
    end
    else
    begin
      sl = 8'(dly);
      sr = half + 8'(dly);
    end
    kl = pos_c - sl;
    kr = pos_c - sr;
    in_l = (pos_c >= sl) && (kl < wlen);
    in_r = (pos_c >= sr) && (kr < wlen) && !in_l;
    load0 = launch && (pos_c == 8'h00);
    word_l = load0 ? nxt_l_r : cur_l_r;
    word_r = load0 ? nxt_r_r : cur_r_r;
    word_v = load0 ? (nxt_vl_r && nxt_vr_r) : cur_v_r;
    idx = in_l ? kl : kr;
    if (tx_port_r.msb_first)
      idx = wlen - 8'h01 - idx;
    ext_w = {8'h00, in_l ? word_l : word_r};
    bit_c = ext_w[idx[4:0]];
    fifo_pop = fifo_valid && !(nxt_vl_r && nxt_vr_r) && !load0;
  end

  // Master bit clock divider and the chosen bit clock level.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      div_r <= 8'h00;
      bclk_gen_r <= 1'b0;
      bck_q_r <= 1'b0;
      bck_p_r <= 1'b0;
    end
    else
    begin
      div_r <= (div_r >= BCLK_HALF_CYC - 8'h01) ? 8'h00 : div_r + 8'h01;
      if (div_r >= BCLK_HALF_CYC - 8'h01)
        bclk_gen_r <= !bclk_gen_r;
      bck_q_r <= tx_port_r.master ? bclk_gen_r : bclk_q;
      bck_p_r <= bck_q_r;
    end
  end

  // Word staging keeps left and right paired; a half-filled pair never starts a frame.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      nxt_vl_r <= 1'b0;
      nxt_vr_r <= 1'b0;
      cur_v_r <= 1'b0;
      nxt_l_r <= '0;
      nxt_r_r <= '0;
      cur_l_r <= '0;
      cur_r_r <= '0;
    end
    else if (load0)
    begin
      cur_l_r <= nxt_l_r;
      cur_r_r <= nxt_r_r;
      cur_v_r <= nxt_vl_r && nxt_vr_r;
      if (nxt_vl_r && nxt_vr_r)
      begin
        nxt_vl_r <= 1'b0;
        nxt_vr_r <= 1'b0;
      end
    end
    else if (fifo_pop)
    begin
      if (!nxt_vl_r)
      begin
        nxt_l_r <= fifo_data;
        nxt_vl_r <= 1'b1;
      end
      else
      begin
        nxt_r_r <= fifo_data;
        nxt_vr_r <= 1'b1;
      end
    end
  end

  // Data pin and its enable and frame clock pin drive at each launch edge; bit clock pin and clock enables every cycle.
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bcnt_r <= RST_POS;
      frm_prev_r <= 1'b0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
      frame_clock_out <= 1'b0;
      frame_clock_oe <= 1'b0;
      bit_clock_out <= 1'b0;
      bit_clock_oe <= 1'b0;
    end
    else
    begin
      bit_clock_out <= bclk_gen_r;
      bit_clock_oe <= tx_port_r.master;
      frame_clock_oe <= tx_port_r.master;
      if (launch)
      begin
        bcnt_r <= pos_c;
        frm_prev_r <= frm_q;
        if (tdm)
          frame_clock_out <= (pos_c == 8'h00) ~^ tx_port_r.frame_left_high;
        else
          frame_clock_out <= (pos_c < half) ~^ tx_port_r.frame_left_high;
        if (word_v && (in_l || in_r) && pos_c != RST_POS && tx_port_r.format != FMT_RSVD)
        begin
          serial_data_out <= bit_c;
          serial_data_oe <= 1'b1;
        end
        else
        begin
          serial_data_out <= 1'b0;
          serial_data_oe <= tx_port_r.tx_idle_drive;
        end
      end
    end
  end
endmodule

// *** verif/apc_regs_chk.sv ***
// Checker bound to the register block ports.
`timescale 1ns/1ns
module apc_regs_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched outputs
  input wire logic smp_ready,
  input wire logic bit_clock_out,
  input wire logic bit_clock_oe,
  input wire logic frame_clock_oe,
  input wire logic bridge_fault_clear,
  input wire apc_pkg::apc_pll_s pll_cfg
);
  import apc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  a_fault_pulse: assert property (bridge_fault_clear |=> !bridge_fault_clear)
    else $error("fault clear too long");
  a_oe_pair: assert property (bit_clock_oe == frame_clock_oe)
    else $error("clock enables differ");
  a_in_div_min: assert property (pll_cfg.run_manual |-> pll_cfg.input_divider != 4'h0)
    else $error("input divider zero");
  a_loop_min: assert property (pll_cfg.run_manual |-> pll_cfg.loop_factor >= LOOP_MIN)
    else $error("loop factor low");
  a_manual_gate: assert property (!pll_cfg.run_manual |-> pll_cfg.loop_factor == 6'h00)
    else $error("divider not gated");
  a_dither_gate: assert property (!pll_cfg.run_manual |-> !pll_cfg.tri_dither_off)
    else $error("dither not gated");
  a_frac_gate: assert property (!pll_cfg.fractional_enable |->
    pll_cfg.fraction_value == 16'h0000) else $error("fraction not gated");
  a_bclk_half: assert property ($changed(bit_clock_out) |=>
    $stable(bit_clock_out) [*7] ##1 $changed(bit_clock_out)) else $error("bit clock period");
  c_fault: cover property (bridge_fault_clear);
  c_full: cover property (!smp_ready);
  c_frac: cover property (pll_cfg.run_manual && pll_cfg.fractional_enable);
endmodule

bind apc_regs apc_regs_chk u_chk (.mclk(mclk), .rst_n(rst_n), .smp_ready(smp_ready),
  .bit_clock_out(bit_clock_out), .bit_clock_oe(bit_clock_oe), .frame_clock_oe(frame_clock_oe),
  .bridge_fault_clear(bridge_fault_clear), .pll_cfg(pll_cfg));

// *** verif/apc_audio_partner.sv ***
// Far-side audio sink that captures the left word, plus link clocks for slave mode.
`timescale 1ns/1ns
module apc_audio_partner (
  // Role and device pins
  input wire logic master,
  input wire logic bco,
  input wire logic fco,
  input wire logic sdo,
  input wire logic sdo_oe,
  // Link clock and capture
  output logic bci = 1'b0,
  output logic fci = 1'b0,
  output logic [23:0] left_word = 24'h000000,
  output logic got = 1'b0
);
  logic fr = 1'b0;
  logic last = 1'b0;
  int pos = 0;
  int bn = 0;
  wire bc = master ? bco : bci;
  wire fc = master ? fco : fci;
  always #80 bci = ~bci;
  // The slave frame clock turns every 32 bit clocks on the launch edge: a 64-bit frame.
  always @(negedge bci)
  begin
    bn = (bn == 31) ? 0 : bn + 1;
    if (bn == 0)
      fci = ~fci;
  end
  // A released data pin shows a toggling level, never a stale bit.
  always @(posedge bc)
  begin
    pos = (fc !== fr) ? 0 : pos + 1;
    fr = fc;
    last = sdo_oe ? sdo : ~last;
    if (fc && pos >= 1 && pos <= 24)
      left_word = {left_word[22:0], last};
    got = fc && pos == 24;
  end
endmodule

// *** verif/apc_regs_test.sv ***
// Self-checking bench for the register block over its two-wire control port.
`timescale 1ns/1ns
module apc_regs_test;
  import apc_pkg::*;
  localparam logic [6:0] ADR = 7'h2a;
  logic mclk, rst_n, scl, sdam, sv, pll_lock, sda_oe, sr, bco, bcoe, fco, sdo, sdoe, fclr;
  logic bci, fci, got, sdao;
  logic [SAMPLE_W-1:0] sd;
  logic [23:0] lw;
  logic [7:0] rd;
  logic [3:0] pop;
  apc_pll_s pc;
  apc_port_s rxp;
  apc_fmt_s rxf;
  int bad_count = 0;
  int comparisons = 0;
  int cyc = 0;
  int pulses = 0;
  int n;
  logic [7:0] ofs [9] = '{8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18};
  logic [7:0] rv [9] = '{8'hd2, 8'h91, 8'hd3, 8'h91, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  wire sda = sdam & ~sda_oe;
  apc_regs #(.DEV_ADDR(ADR)) dut (.mclk(mclk), .rst_n(rst_n), .i2c_scl(scl), .i2c_sda_in(sda),
    .i2c_sda_out(sdao), .i2c_sda_oe(sda_oe), .smp_valid(sv), .smp_ready(sr), .smp_data(sd),
    .bit_clock_input(bci), .frame_clock_input(fci), .bit_clock_out(bco), .bit_clock_oe(bcoe),
    .frame_clock_out(fco), .frame_clock_oe(), .serial_data_out(sdo), .serial_data_oe(sdoe),
    .pll_lock(pll_lock), .pll_cfg(pc), .rx_port_cfg(rxp), .rx_fmt_cfg(rxf), .popfree_out(pop),
    .bridge_fault_clear(fclr));
  apc_audio_partner u_far (.master(bcoe), .bco(bco), .fco(fco), .sdo(sdo), .sdo_oe(sdoe),
    .bci(bci), .fci(fci), .left_word(lw), .got(got));
  initial
  begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    pulses <= pulses + int'(fclr === 1'b1);
    if (cyc == 40000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task bitw(input logic b);
    sdam = b;
    #40 scl = 1;
    #80 scl = 0;
    #40;
  endtask
  task wb(input logic [7:0] b);
    for (int k = 0; k < 8; k++) bitw(b[7-k]);
    sdam = 1;
    #40 scl = 1;
    #40 chk(24'(sda), 24'h0);
    #40 scl = 0;
    #40;
  endtask
  task rb(output logic [7:0] b);
    sdam = 1;
    for (int k = 0; k < 8; k++)
    begin
      #40 scl = 1;
      #40 b[7-k] = sda;
      #40 scl = 0;
      #40;
    end
    bitw(1'b1);
  endtask
  // Start and repeated start share one shape: SDA falls while SCL is high.
  task strt;
    sdam = 1;
    #40 scl = 1;
    #40 sdam = 0;
    #40 scl = 0;
    #40;
  endtask
  task sp;
    sdam = 0;
    #40 scl = 1;
    #40 sdam = 1;
    #80;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    strt;
    wb({ADR, 1'b0});
    wb(a);
    wb(d);
    sp;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] e);
    strt;
    wb({ADR, 1'b0});
    wb(a);
    strt;
    wb({ADR, 1'b1});
    rb(rd);
    sp;
    chk(24'(rd), 24'(e));
  endtask
  initial
  begin
    scl = 1;
    sdam = 1;
    sv = 0;
    sd = 0;
    pll_lock = 0;
    rst_n = 0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1;
    repeat (4) @(posedge mclk);
    #1;
    for (int k = 0; k < 9; k++) rc(ofs[k], rv[k]);
    rc(8'h30, 8'h00);
    wr(8'h0b, 8'h6e);
    chk(24'({rxf, sdao}), 24'hdc);
    wr(8'h0a, 8'hd3);
    chk(24'(rxp.master), 24'h1);
    wr(8'h14, 8'hd0);
    wr(8'h15, 8'hbe);
    wr(8'h16, 8'hef);
    wr(8'h17, 8'hc3);
    chk(24'(pc.input_divider), 24'h1);
    chk(24'(pc.loop_factor), 24'h5);
    chk(24'({pc.fraction_strobe, pc.strobe_bypass}), 24'h3);
    chk(24'(pc.fraction_value), 24'hbeef);
    chk(24'({pc.rect_dither_off, pc.tri_dither_off}), 24'h1);
    wr(8'h14, 8'h0f);
    chk(24'(pc.loop_factor), 24'h0);
    wr(8'h14, 8'h8f);
    chk(24'(pc.input_divider), 24'hf);
    wr(8'h18, 8'hbf);
    chk(24'(pop), 24'hf);
    chk(24'({pc.bypass_when_unlocked, pc.bitclk_as_reference, pc.pll_power_off}),
        24'h5);
    rc(8'h18, 8'hbe);
    rc(8'h19, 8'he0);
    wr(8'h19, 8'h00);
    pll_lock = 1;
    rc(8'h19, 8'h40);
    wr(8'h18, 8'h02);
    chk(24'(pop), 24'h1);
    chk(24'(pulses), 24'h1);
    wr(8'h0c, 8'hf2);
    chk(24'(bcoe), 24'h0);
    chk(24'({sdoe, sdo}), 24'h2);
    wr(8'h0c, 8'hd3);
    chk(24'({sdoe, sdo}), 24'h0);
    sv = 1;
    n = 0;
    while (sr === 1'b1 && n < 24)
    begin
      sd = (n == 0) ? 24'ha5c3e1 : 24'h0f0f00 + 24'(n);
      @(posedge mclk);
      #1 n++;
    end
    sv = 0;
    chk(24'(n < 24), 24'h1);
    for (int k = 0; k < 3000 && !(got === 1'b1 && lw === 24'ha5c3e1); k++) @(posedge mclk);
    chk(lw, 24'ha5c3e1);
    tally_and_finish;
  end
endmodule
